// ### src/sebt_target.sv
// Purpose: two-wire serial bus target with a 1024-byte page-organised memory
// Assumes: scl and sda arrive asynchronously; core_clk much faster than scl
// Notes: the array is a plain register array, write cycle modelled by a timer
//
// Summary of operation
// - sample data on serial clock rise, change output after its fall
// - data line is only pulled low or released, never driven high
// - protect input low allows normal reads and writes
// - protect input high blocks all array writes, reads still allowed
// - memory is 64 pages of 16 bytes, 10-bit byte address
// - data change while clock high is taken as start or stop
// - falling data with clock high is start, seen at any point outside the write cycle
// - rising data with clock high is stop, ends the transfer
// - stop after a read returns the device to standby
// - 8-bit words msb first, device pulls data low on ninth clock
// - standby after reset and after stop once internal work is done
// - clocking out then start and stop returns the device to idle
// - device word is 1010, zero, two page bits, read/write bit
// - page bits form address bits 9 and 8, next byte the low eight
// - read/write bit one starts a read, zero starts a write
// - matching device word is acknowledged, otherwise back to standby
// - stop after a write runs a timed write cycle, bus ignored meanwhile
// - page write increments only the low four address bits
// - no acknowledge to the device word while the write cycle runs
// - address counter holds last address plus one, reads wrap whole array
`timescale 1ns/1ps
`default_nettype none
module sebt_target
    import sebt_pkg::*;
#(
    parameter int unsigned WR_CYCLE_CLKS = WRITE_CYCLE_CLKS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // write protect strap
    input wire logic wp_in,
    // status
    output logic standby,
    output logic write_busy
);
    import sebt_pkg::*;

    // ----------------------------------------
    // reset release and input synchronisers
    // ----------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // reset values match the idle bus, so no false start or stop follows reset
    logic [2:0] meta_ff, sync_ff, nxt_meta, nxt_sync;
    logic scl_d_ff, sda_d_ff, nxt_scl_d, nxt_sda_d;
    always_comb begin
        nxt_meta = {scl_in, sda_in, wp_in};
        nxt_sync = meta_ff;
        nxt_scl_d = sync_ff[2];
        nxt_sda_d = sync_ff[1];
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 3'h7;
            sync_ff <= 3'h7;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            scl_d_ff <= nxt_scl_d;
            sda_d_ff <= nxt_sda_d;
        end
    end

    logic scl_s, sda_s, wp_s;
    sebt_evt_t evt;
    assign scl_s = sync_ff[2];
    assign sda_s = sync_ff[1];
    assign wp_s = sync_ff[0];
    always_comb begin
        evt.start = scl_s && scl_d_ff && sda_d_ff && !sda_s;
        evt.stop = scl_s && scl_d_ff && !sda_d_ff && sda_s;
        evt.scl_rise = scl_s && !scl_d_ff;
        evt.scl_fall = !scl_s && scl_d_ff;
    end

    // ----------------------------------------
    // memory array
    // ----------------------------------------
    // read data muxes straight out of the array, so it maps to flops, not a ram macro
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    // ----------------------------------------
    // protocol state
    // ----------------------------------------
    sebt_state_t state_ff, nxt_state, ret_ff, nxt_ret;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    logic [DATA_W-1:0] shift_ff, nxt_shift;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic rd_ff, nxt_rd;
    logic wrote_ff, nxt_wrote;
    logic ack_go_ff, nxt_ack_go;
    logic sda_oe_ff, nxt_sda_oe;
    logic sda_out_ff, nxt_sda_out;
    logic standby_ff, nxt_standby;
    logic busy_ff, nxt_busy;
    logic [31:0] wr_cnt_ff, nxt_wr_cnt;
    logic mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [DATA_W-1:0] mem_wd;

    function automatic logic dev_match(input logic [DATA_W-1:0] w);
        return w[DEV_ID_MSB:DEV_ID_LSB] == DEV_ID_PATTERN;
    endfunction

    always_comb begin
        nxt_state = state_ff;
        nxt_ret = ret_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_addr = addr_ff;
        nxt_rd = rd_ff;
        nxt_wrote = wrote_ff;
        nxt_ack_go = ack_go_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_sda_out = 1'b0;
        nxt_standby = standby_ff;
        nxt_busy = busy_ff;
        nxt_wr_cnt = wr_cnt_ff;
        mem_we = 1'b0;
        mem_wa = addr_ff;
        mem_wd = shift_ff;
        if (busy_ff) begin
            // bus inputs ignored while the array is being written
            // polling therefore sees the line left alone, which reads as no acknowledge
            if (wr_cnt_ff >= WR_CYCLE_CLKS - 1) begin
                nxt_busy = 1'b0;
                nxt_standby = 1'b1;
                nxt_wr_cnt = 32'h0;
            end else begin
                nxt_wr_cnt = wr_cnt_ff + 32'h1;
            end
            nxt_state = SEBT_IDLE;
            nxt_sda_oe = 1'b0;
        end else if (evt.stop) begin
            nxt_state = SEBT_IDLE;
            nxt_sda_oe = 1'b0;
            if (wrote_ff) begin
                nxt_busy = 1'b1;
                nxt_wr_cnt = 32'h0;
                nxt_standby = 1'b0;
            end else begin
                nxt_standby = 1'b1;
            end
            nxt_wrote = 1'b0;
        end else if (evt.start) begin
            nxt_state = SEBT_DEVADR;
            nxt_bit_cnt = 4'h0;
            nxt_sda_oe = 1'b0;
            nxt_standby = 1'b0;
            nxt_wrote = 1'b0;
        end else begin
            case (state_ff)
                SEBT_DEVADR, SEBT_WORDADR, SEBT_WRDATA: begin
                    if (evt.scl_rise) begin
                        nxt_shift = {shift_ff[DATA_W-2:0], sda_s};
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end else if (evt.scl_fall && bit_cnt_ff == BITS_PER_WORD) begin
                        nxt_bit_cnt = 4'h0;
                        nxt_ack_go = 1'b1;
                        nxt_ret = state_ff;
                        if (state_ff == SEBT_DEVADR) begin
                            if (dev_match(shift_ff)) begin
                                nxt_sda_oe = 1'b1;
                                nxt_rd = shift_ff[RW_POS];
                                nxt_addr[ADDR_W-1] = shift_ff[PAGE_HI_POS];
                                nxt_addr[ADDR_W-2] = shift_ff[PAGE_LO_POS];
                                nxt_state = SEBT_ACK;
                            end else begin
                                nxt_state = SEBT_IDLE;
                                nxt_standby = 1'b1;
                            end
                        end else if (state_ff == SEBT_WORDADR) begin
                            nxt_addr[DATA_W-1:0] = shift_ff;
                            nxt_sda_oe = 1'b1;
                            nxt_state = SEBT_ACK;
                        end else begin
                            mem_we = !wp_s;
                            nxt_wrote = 1'b1;
                            nxt_addr[PAGE_BITS-1:0] = addr_ff[PAGE_BITS-1:0] + 4'h1;
                            nxt_sda_oe = 1'b1;
                            nxt_state = SEBT_ACK;
                        end
                    end
                end
                SEBT_ACK: begin
                    // ack stays low across the ninth clock; after its fall the line is released, or for a read takes the first data bit
                    if (evt.scl_fall) begin
                        nxt_ack_go = 1'b0;
                        if (ret_ff == SEBT_DEVADR && rd_ff) begin
                            nxt_state = SEBT_RDDATA;
                            nxt_shift = mem[addr_ff];
                            nxt_sda_oe = !mem[addr_ff][DATA_W-1];
                            nxt_bit_cnt = 4'h1;
                        end else begin
                            nxt_sda_oe = 1'b0;
                            nxt_state = (ret_ff == SEBT_DEVADR) ? SEBT_WORDADR : SEBT_WRDATA;
                        end
                    end
                end
                SEBT_RDDATA: begin
                    if (evt.scl_fall) begin
                        if (bit_cnt_ff == BITS_PER_WORD) begin
                            nxt_sda_oe = 1'b0;
                            nxt_bit_cnt = 4'h0;
                            nxt_addr = addr_ff + 10'h001;
                            nxt_state = SEBT_MACK;
                        end else begin
                            nxt_sda_oe = !shift_ff[DATA_W-1-bit_cnt_ff[2:0]];
                            nxt_bit_cnt = bit_cnt_ff + 4'h1;
                        end
                    end
                end
                SEBT_MACK: begin
                    if (evt.scl_rise) begin
                        nxt_bit_cnt = sda_s ? 4'hF : 4'h0;
                    end else if (evt.scl_fall) begin
                        if (bit_cnt_ff == 4'h0) begin
                            nxt_state = SEBT_RDDATA;
                            nxt_shift = mem[addr_ff];
                            nxt_sda_oe = !mem[addr_ff][DATA_W-1];
                            nxt_bit_cnt = 4'h1;
                        end else begin
                            nxt_state = SEBT_IDLE; // controller ended the read
                        end
                    end
                end
                default: begin
                    nxt_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SEBT_IDLE;
            ret_ff <= SEBT_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            addr_ff <= ADDR_RESET;
            rd_ff <= 1'b0;
            wrote_ff <= 1'b0;
            ack_go_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            sda_out_ff <= 1'b0;
            standby_ff <= 1'b1;
            busy_ff <= 1'b0;
            wr_cnt_ff <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            ret_ff <= nxt_ret;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            addr_ff <= nxt_addr;
            rd_ff <= nxt_rd;
            wrote_ff <= nxt_wrote;
            ack_go_ff <= nxt_ack_go;
            sda_oe_ff <= nxt_sda_oe;
            sda_out_ff <= nxt_sda_out;
            standby_ff <= nxt_standby;
            busy_ff <= nxt_busy;
            wr_cnt_ff <= nxt_wr_cnt;
        end
    end

    // array content has no reset; it is the nonvolatile store
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign sda_out = sda_out_ff;
    assign sda_oe = sda_oe_ff;
    assign standby = standby_ff;
    assign write_busy = busy_ff;
endmodule // sebt_target
`default_nettype wire

// ### src/sebt_pkg.sv
// Purpose: constants and types for the two-wire serial memory target
// Assumes: core clock at 25 MHz, serial clock sampled as a plain input
// Notes: timing counts derived from printed times
package sebt_pkg;
    localparam int unsigned CORE_CLK_HZ = 25000000;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MEM_DEPTH = 1024;
    localparam int unsigned PAGE_BITS = 4;
    // device address word fields
    localparam logic [4:0] DEV_ID_PATTERN = 5'h14;
    localparam int unsigned DEV_ID_MSB = 7;
    localparam int unsigned DEV_ID_LSB = 3;
    localparam int unsigned PAGE_HI_POS = 2;
    localparam int unsigned PAGE_LO_POS = 1;
    localparam int unsigned RW_POS = 0;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;
    // self-timed write cycle, longest printed time
    localparam int unsigned WRITE_CYCLE_US = 3000;
    localparam int unsigned WRITE_CYCLE_CLKS = WRITE_CYCLE_US * (CORE_CLK_HZ / 1000000);
    localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;

    typedef enum logic [6:0] {
        SEBT_IDLE    = 7'h01,
        SEBT_DEVADR  = 7'h02,
        SEBT_WORDADR = 7'h04,
        SEBT_WRDATA  = 7'h08,
        SEBT_RDDATA  = 7'h10,
        SEBT_ACK     = 7'h20,
        SEBT_MACK    = 7'h40
    } sebt_state_t;

    // bus line events seen by the core clock
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } sebt_evt_t;
endpackage

// ### bench/sebt_target_chk.sv
// Purpose: port checks for the serial memory target
// Assumes: serial clock low 5 and high 3 core clocks
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module sebt_target_chk
    import sebt_pkg::*;
#(
    parameter int unsigned WR_CYCLE_CLKS = 400
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // bus and status
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic wp_in,
    input wire logic standby,
    input wire logic write_busy
);
    int unsigned busy_cnt_ff;
    int unsigned nxt_busy_cnt;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ----
    // write cycle length
    // ----
    always_comb begin
        nxt_busy_cnt = write_busy ? busy_cnt_ff + 1 : 0;
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt_ff <= 0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end
    sequence s_held;
        sda_oe [*3];
    endsequence
    a_drive_low: assert property (sda_out == 1'b0)
        else $error("data pin value not low");
    a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("drive began with clock high");
    a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("release with clock high");
    a_hold_high: assert property ($rose(scl_in) && sda_oe |-> s_held)
        else $error("drive dropped while clock high");
    a_busy_quiet: assert property (write_busy |-> !sda_oe)
        else $error("drive during write cycle");
    a_idle_quiet: assert property (standby |-> !sda_oe)
        else $error("drive in standby");
    a_busy_length: assert property ($fell(write_busy) |->
        busy_cnt_ff >= WR_CYCLE_CLKS - 1 && busy_cnt_ff <= WR_CYCLE_CLKS + 1)
        else $error("write cycle length wrong");
    a_busy_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
        else $error("write cycle without stop");
endmodule // sebt_target_chk
bind sebt_target sebt_target_chk #(.WR_CYCLE_CLKS(WR_CYCLE_CLKS)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .standby(standby),
    .write_busy(write_busy));
`default_nettype wire

// ### bench/sebt_ctrl_model.sv
// Purpose: two-wire bus controller model
// Assumes: paced by core clock falling edges
// Notes: data line has a pull-up; clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module sebt_ctrl_model (
    // pacing
    input wire logic clk,
    // device drive
    input wire logic dev_oe,
    input wire logic dev_out,
    // bus lines
    output logic scl,
    output logic sda
);
    logic m_sda;
    // wired-and with pull-up, so a released line reads high
    assign sda = (dev_oe ? dev_out : 1'b1) & m_sda;
    initial begin
        scl = 1'b1;
        m_sda = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // waits out a late ack release before raising the clock
    task automatic start();
        m_sda = 1'b1;
        tk(4);
        scl = 1'b1;
        tk(3);
        m_sda = 1'b0;
        tk(3);
        scl = 1'b0;
        tk(1);
    endtask
    task automatic stop();
        m_sda = 1'b0;
        tk(4);
        scl = 1'b1;
        tk(3);
        m_sda = 1'b1;
        tk(3);
    endtask
    task automatic clk_bit(input logic b, output logic s);
        m_sda = b;
        tk(4);
        scl = 1'b1;
        tk(2);
        s = sda;
        tk(1);
        scl = 1'b0;
        tk(1);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(!mack, s);
    endtask
    // clock until the line is seen high with the clock high, then start and stop
    task automatic recover(output int n);
        logic s;
        n = 0;
        s = 1'b0;
        while (!s && n < 9) begin
            m_sda = 1'b1;
            tk(4);
            scl = 1'b1;
            tk(2);
            s = sda;
            n++;
            if (!s) begin
                tk(1);
                scl = 1'b0;
                tk(1);
            end
        end
        tk(1);
        m_sda = 1'b0;
        tk(3);
        scl = 1'b0;
        tk(1);
        stop();
    endtask
endmodule // sebt_ctrl_model
`default_nettype wire

// ### bench/sebt_target_tb.sv
// Purpose: self-checking bench for the serial memory target
// Assumes: serial clock 320 ns, write cycle cut to 400 clocks
// Notes: a shadow array holds the expected memory
`timescale 1ns/1ps
`default_nettype none
module sebt_target_tb;
    import sebt_pkg::*;
    localparam int unsigned WR = 400;
    logic core_clk, rst_b, wp_in, sda_out, sda_oe, standby, write_busy;
    wire scl;
    wire sda;
    logic [7:0] shadow [MEM_DEPTH];
    int err_total;
    int compares;
    sebt_target #(.WR_CYCLE_CLKS(WR)) uut (.core_clk(core_clk), .rst_b(rst_b),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .wp_in(wp_in), .standby(standby), .write_busy(write_busy));
    sebt_ctrl_model m (.clk(core_clk), .dev_oe(sda_oe), .dev_out(sda_out),
        .scl(scl), .sda(sda));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic a;
        m.wr_byte(d, a);
        chk("ack", 8'(a), 8'(exp_ack));
    endtask
    task automatic addr_phase(input logic [9:0] a);
        m.start();
        send({4'hA, 1'b0, a[9:8], 1'b0}, 1'b1);
        send(a[7:0], 1'b1);
    endtask
    task automatic do_write(input logic [9:0] a, input logic [7:0] d0, input int n);
        addr_phase(a);
        for (int i = 0; i < n; i++) begin
            send(d0 + 8'(i), 1'b1);
            if (!wp_in) shadow[a] = d0 + 8'(i);
            a[3:0] = a[3:0] + 4'h1;
        end
        m.stop();
        repeat (8) @(negedge core_clk);
        chk("busy", 8'(write_busy), 8'h01);
        m.start();
        send(8'hA0, 1'b0);
        m.stop();
        for (int k = 0; k < WR && write_busy; k++) @(negedge core_clk);
        chk("busy", 8'(write_busy), 8'h00);
        repeat (4) @(negedge core_clk);
        chk("standby", 8'(standby), 8'h01);
    endtask
    task automatic do_read(input logic [9:0] a, input int n);
        logic [7:0] d;
        addr_phase(a);
        m.start();
        send({4'hA, 1'b0, a[9:8], 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.rd_byte(i < n - 1, d);
            chk("rdata", d, shadow[a]);
            a = a + 10'h001;
        end
        m.stop();
        repeat (6) @(negedge core_clk);
        chk("standby", 8'(standby), 8'h01);
    endtask
    task automatic s_write_read();
        chk("standby", 8'(standby), 8'h01);
        chk("oe", 8'(sda_oe), 8'h00);
        do_write(10'h000, 8'h5A, 1);
        do_write(10'h3F0, 8'h10, 17);
        do_read(10'h3FE, 3);
        do_read(10'h3F0, 2);
    endtask
    task automatic s_protect();
        wp_in = 1'b1;
        do_write(10'h000, 8'hC3, 1);
        wp_in = 1'b0;
        do_read(10'h000, 1);
    endtask
    task automatic s_nomatch_abort();
        logic [7:0] bad [3] = '{8'hB0, 8'hA8, 8'h28};
        logic s;
        foreach (bad[i]) begin
            m.start();
            send(bad[i], 1'b0);
            m.stop();
            chk("standby", 8'(standby), 8'h01);
        end
        m.start();
        send(8'hA0, 1'b1);
        for (int i = 0; i < 4; i++) m.clk_bit(1'b0, s);
        m.stop();
        repeat (6) @(negedge core_clk);
        chk("oe", 8'(sda_oe), 8'h00);
        chk("standby", 8'(standby), 8'h01);
        do_read(10'h3F1, 1);
    endtask
    task automatic s_recover();
        int n;
        addr_phase(10'h000);
        m.start();
        send(8'hA1, 1'b1);
        // stored byte 0x5A leads with a low bit, so the line is first high on clock two
        m.recover(n);
        chk("recover", 8'(n), 8'h02);
        repeat (6) @(negedge core_clk);
        chk("oe", 8'(sda_oe), 8'h00);
        chk("standby", 8'(standby), 8'h01);
        do_read(10'h000, 1);
    endtask
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        #1000000;
        err_total++;
        stop_test();
    end
    initial begin
        rst_b = 1'b0;
        wp_in = 1'b0;
        err_total = 0;
        compares = 0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge core_clk);
        s_write_read();
        s_protect();
        s_nomatch_abort();
        s_recover();
        stop_test();
    end
endmodule // sebt_target_tb
`default_nettype wire
